// ==== hdl/smpwm_pkg.sv ====
package smpwm_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_TB_CTL  = 8'h00;
  localparam logic [7:0] OFF_PERIOD  = 8'h04;
  localparam logic [7:0] OFF_DUTY    = 8'h08;
  localparam logic [7:0] OFF_PHASE   = 8'h0c;
  localparam logic [7:0] OFF_OUT_CTL = 8'h10;
  localparam logic [7:0] OFF_BLANK   = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // Widths
  localparam int CNT_W   = 13;
  localparam int BLCNT_W = 8;

  // time_base_control fields
  localparam int TB_EN_BIT   = 0;
  localparam int TB_SYNC_BIT = 1;
  localparam int TB_SRC_LO   = 2;
  localparam int TB_W        = 5;

  // output_control fields
  localparam int OC_MODE_LO = 0;
  localparam int OC_CLM_BIT = 2;
  localparam int OC_CRM_BIT = 3;
  localparam int OC_FDL_BIT = 4;
  localparam int OC_FDH_BIT = 5;
  localparam int OC_FEN_BIT = 6;
  localparam int OC_W       = 7;

  // blanking_control fields
  localparam int BL_HR_BIT  = 15;
  localparam int BL_HF_BIT  = 14;
  localparam int BL_LR_BIT  = 13;
  localparam int BL_LF_BIT  = 12;
  localparam int BL_FLT_BIT = 11;
  localparam int BL_CL_BIT  = 10;
  localparam int BL_DUR_HI  = 9;
  localparam int BL_DUR_LO  = 3;
  localparam logic [15:0] BL_MASK = 16'hfff8;

  // Pin pair modes
  localparam logic [1:0] MODE_COMPL = 2'h0;
  localparam logic [1:0] MODE_INDEP = 2'h1;
  localparam logic [1:0] MODE_PP    = 2'h2;

  // Blanking step: time in ns and its cycle count, rounded up
  localparam int CLK_PERIOD_NS = 5;
  localparam int BLANK_STEP_NS = 8;
  localparam int BLANK_STEP_CYC =
    (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Time base state, Gray along idle -> run
  typedef enum logic [1:0] {
    SMPWM_IDLE = 2'b00,
    SMPWM_RUN  = 2'b01
  } smpwm_state_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } smpwm_apb_req_t;

  // All state of the generator
  typedef struct packed {
    smpwm_state_t         st;
    logic [TB_W-1:0]      tb_ctl;
    logic [CNT_W-1:0]     period;
    logic [CNT_W-1:0]     duty;
    logic [CNT_W-1:0]     phase;
    logic [OC_W-1:0]      out_ctl;
    logic [15:0]          blank;
    logic [CNT_W-1:0]     pcnt;
    logic [CNT_W-1:0]     duty_act;
    logic [CNT_W-1:0]     phase_act;
    logic                 pp_sel;
    logic                 hi;
    logic                 lo;
    logic [BLCNT_W-1:0]   blcnt;
    logic                 flt_latch;
    logic                 cl_latch;
    logic                 sync_pulse;
    logic                 trig;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
  } smpwm_state_s_t;

endpackage

// ==== hdl/smpwm_top.sv ====
// Functional notes
// - High output edges start blanking when enabled.
// - Low output edges start blanking when enabled.
// - Fault input blanked when its enable set.
// - Current-limit input blanked when enable set.
// - Duration bits 9:3, two 5 ns cycles (10 ns) per count.
// - Output asserted while counter <= duty.
// - Output deasserted once counter exceeds duty.
// - Counter resets after reaching period.
// - Complementary mode: low is inverse of high.
// - Push-pull alternates high and low each cycle.
// - Push-pull phases share identical duty.
// - Phase added to primary counter.
// - Current limit truncates output, applies override data.
// - Override holds until next cycle begins.
// - Current reset restarts time base after off.
// - Constant off-time uses current reset, complement.
// - Primary rollover loads duty and phase.
// - Primary time base makes event trigger.
// - External sync resets time base on source.
// - Period match emits sync output pulse.
// - Fault data bit1 drives high, bit0 low.
module smpwm_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [7:0]  sync_src_in,
  input  wire logic        fault_in,
  input  wire logic        curlim_in,
  input  wire logic        cur_reset_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  output logic             high_output_out,
  output logic             low_output_out,
  output logic             sync_pulse_out,
  output logic             trig_out
);

  smpwm_pkg::smpwm_apb_req_t req;        // Bundled bus request
  smpwm_pkg::smpwm_state_s_t state_reg;  // All flops
  smpwm_pkg::smpwm_state_s_t state_next; // Their next value

  assign req.psel    = psel_in;
  assign req.penable = penable_in;
  assign req.pwrite  = pwrite_in;
  assign req.paddr   = paddr_in;
  assign req.pwdata  = pwdata_in;

  localparam int BLCNT_W = smpwm_pkg::BLCNT_W; // Blank counter width

  // Next-state logic for time base, waveform, blanking and registers
  always_comb begin
    logic [smpwm_pkg::CNT_W-1:0]   gen_cnt;   // Generator count
    logic                          wave;      // Raw active waveform
    logic                          match;     // Primary period match
    logic                          ext_rst;   // External time base reset
    logic                          start;     // New PWM cycle begins
    logic                          blanking;  // Blank window open
    logic                          flt_seen;  // Fault after blanking
    logic                          cl_seen;   // Limit after blanking
    logic                          ovr;       // Override in force
    logic                          hi_n;      // Next high output
    logic                          lo_n;      // Next low output
    logic                          trig_edge; // Any enabled edge
    logic [6:0]                    dur;       // Blank duration field
    logic                          access;    // Completing bus beat
    logic [31:0]                   rdata;     // Read mux
    logic                          mapped;    // Address decodes
    state_next = state_reg;
    gen_cnt    = '0;
    wave       = 1'b0;
    match      = 1'b0;
    ext_rst    = 1'b0;
    start      = 1'b0;
    blanking   = 1'b0;
    flt_seen   = 1'b0;
    cl_seen    = 1'b0;
    ovr        = 1'b0;
    hi_n       = 1'b0;
    lo_n       = 1'b0;
    trig_edge  = 1'b0;
    dur        = '0;
    access     = 1'b0;
    rdata      = '0;
    mapped     = 1'b1;
    state_next.sync_pulse = 1'b0;
    state_next.trig       = 1'b0;

    // Blanking gates the inputs for as long as the counter runs
    blanking = (state_reg.blcnt != '0);
    flt_seen = fault_in &
      ~(state_reg.blank[smpwm_pkg::BL_FLT_BIT] & blanking);
    cl_seen = curlim_in &
      ~(state_reg.blank[smpwm_pkg::BL_CL_BIT] & blanking);

    case (state_reg.st)
      // Disabled: counters and latches cleared, shadows loaded, outputs low
      smpwm_pkg::SMPWM_IDLE: begin
        state_next.pcnt      = '0;
        state_next.pp_sel    = 1'b0;
        state_next.hi        = 1'b0;
        state_next.lo        = 1'b0;
        state_next.blcnt     = '0;
        state_next.flt_latch = 1'b0;
        state_next.cl_latch  = 1'b0;
        state_next.duty_act  = state_reg.duty;
        state_next.phase_act = state_reg.phase;
        if (state_reg.tb_ctl[smpwm_pkg::TB_EN_BIT]) begin
          state_next.st = smpwm_pkg::SMPWM_RUN;
        end
      end
      // Running time base
      smpwm_pkg::SMPWM_RUN: begin
        // Phase shift pulls the generator ahead of the primary count
        gen_cnt = state_reg.pcnt + state_reg.phase_act;
        wave = (gen_cnt <= state_reg.duty_act);
        match = (state_reg.pcnt >= state_reg.period);
        // Sync source chosen by the three-bit select
        if (state_reg.tb_ctl[smpwm_pkg::TB_SYNC_BIT] &&
            sync_src_in[state_reg.tb_ctl[smpwm_pkg::TB_SRC_LO +: 3]]) begin
          ext_rst = 1'b1;
        end
        // Reset honoured only once the on-time is over
        if (state_reg.out_ctl[smpwm_pkg::OC_CRM_BIT] && cur_reset_in &&
            !wave) begin
          ext_rst = 1'b1;
        end
        start = match | ext_rst;
        if (start) begin
          state_next.pcnt = '0;
          // Shadows load only when a new cycle starts (period match or external reset), so a cycle never tears
          state_next.duty_act  = state_reg.duty;
          state_next.phase_act = state_reg.phase;
          state_next.pp_sel    = ~state_reg.pp_sel;
          state_next.flt_latch = 1'b0;
          state_next.cl_latch  = 1'b0;
        end else begin
          state_next.pcnt = state_reg.pcnt + 1'b1;
        end
        if (match) begin
          state_next.sync_pulse = 1'b1;
          state_next.trig       = 1'b1;
        end
        // Fault and limit latch until the next cycle starts; a trip in
        // the start cycle wins over the clear, so it is never lost
        if (state_reg.out_ctl[smpwm_pkg::OC_FEN_BIT] && flt_seen) begin
          state_next.flt_latch = 1'b1;
        end
        if (state_reg.out_ctl[smpwm_pkg::OC_CLM_BIT] && cl_seen) begin
          state_next.cl_latch = 1'b1;
        end
        ovr = state_next.flt_latch | state_next.cl_latch;
        // Pin pair steering
        case (state_reg.out_ctl[smpwm_pkg::OC_MODE_LO +: 2])
          smpwm_pkg::MODE_COMPL: begin
            hi_n = wave;
            lo_n = ~wave;
          end
          smpwm_pkg::MODE_INDEP: begin
            hi_n = wave;
            lo_n = wave;
          end
          smpwm_pkg::MODE_PP: begin
            // Same duty compare feeds both pins, so no DC bias
            hi_n = wave & ~state_next.pp_sel;
            lo_n = wave & state_next.pp_sel;
          end
          default: begin
            hi_n = 1'b0;
            lo_n = 1'b0;
          end
        endcase
        // Pins follow the compare one stage late, so each full cycle shows
        // duty + 1 - phase asserted counts
        if (ovr) begin
          hi_n = state_reg.out_ctl[smpwm_pkg::OC_FDH_BIT];
          lo_n = state_reg.out_ctl[smpwm_pkg::OC_FDL_BIT];
        end
        state_next.hi = hi_n;
        state_next.lo = lo_n;
        // Enabled output edges retrigger the blanking window
        trig_edge =
          (state_reg.blank[smpwm_pkg::BL_HR_BIT] & hi_n & ~state_reg.hi) |
          (state_reg.blank[smpwm_pkg::BL_HF_BIT] & ~hi_n & state_reg.hi) |
          (state_reg.blank[smpwm_pkg::BL_LR_BIT] & lo_n & ~state_reg.lo) |
          (state_reg.blank[smpwm_pkg::BL_LF_BIT] & ~lo_n & state_reg.lo);
        dur = state_reg.blank[smpwm_pkg::BL_DUR_HI:smpwm_pkg::BL_DUR_LO];
        if (trig_edge) begin
          // Each count adds one 8 ns step, rounded up to whole cycles
          state_next.blcnt =
            BLCNT_W'(dur * smpwm_pkg::BLANK_STEP_CYC);
        end else if (blanking) begin
          state_next.blcnt = state_reg.blcnt - 1'b1;
        end
        if (!state_reg.tb_ctl[smpwm_pkg::TB_EN_BIT]) begin
          state_next.st = smpwm_pkg::SMPWM_IDLE;
        end
      end
      default: begin
        state_next.st = smpwm_pkg::SMPWM_IDLE;
      end
    endcase

    // APB slave: one wait state, then pready for one cycle
    access = req.psel & req.penable & state_reg.pready;
    case (req.paddr)
      smpwm_pkg::OFF_TB_CTL:  rdata = 32'(state_reg.tb_ctl);
      smpwm_pkg::OFF_PERIOD:  rdata = 32'(state_reg.period);
      smpwm_pkg::OFF_DUTY:    rdata = 32'(state_reg.duty);
      smpwm_pkg::OFF_PHASE:   rdata = 32'(state_reg.phase);
      smpwm_pkg::OFF_OUT_CTL: rdata = 32'(state_reg.out_ctl);
      smpwm_pkg::OFF_BLANK:   rdata = 32'(state_reg.blank);
      smpwm_pkg::OFF_STATUS:  rdata = 32'({state_reg.cl_latch,
                                           state_reg.flt_latch,
                                           state_reg.lo, state_reg.hi,
                                           state_reg.pcnt});
      default: begin
        rdata  = '0;
        mapped = 1'b0;
      end
    endcase
    if (req.psel && req.penable && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = ~mapped;
      state_next.prdata  = req.pwrite ? '0 : rdata;
    end else begin
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;
      state_next.prdata  = '0;
    end
    // Writes land on the completing edge only
    if (access && req.pwrite && mapped) begin
      case (req.paddr)
        smpwm_pkg::OFF_TB_CTL:
          state_next.tb_ctl = req.pwdata[smpwm_pkg::TB_W-1:0];
        smpwm_pkg::OFF_PERIOD:
          state_next.period = req.pwdata[smpwm_pkg::CNT_W-1:0];
        smpwm_pkg::OFF_DUTY:
          state_next.duty = req.pwdata[smpwm_pkg::CNT_W-1:0];
        // Phase should only move while the output is off
        smpwm_pkg::OFF_PHASE:
          state_next.phase = req.pwdata[smpwm_pkg::CNT_W-1:0];
        smpwm_pkg::OFF_OUT_CTL:
          state_next.out_ctl = req.pwdata[smpwm_pkg::OC_W-1:0];
        smpwm_pkg::OFF_BLANK:
          state_next.blank = req.pwdata[15:0] & smpwm_pkg::BL_MASK;
        default: begin
          state_next.tb_ctl = state_next.tb_ctl;
        end
      endcase
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign pready_out      = state_reg.pready;
  assign pslverr_out     = state_reg.pslverr;
  assign prdata_out      = state_reg.prdata;
  assign high_output_out = state_reg.hi;
  assign low_output_out  = state_reg.lo;
  assign sync_pulse_out  = state_reg.sync_pulse;
  assign trig_out        = state_reg.trig;

endmodule

// ==== bench/smpwm_far_model.sv ====
// Far side: a comparator that trips a few cycles after each switch turn-on,
// and an external sync source. Released lines have pull-downs, so they idle
// at 0.
module smpwm_far_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       high_output_in, // Watched switch drive
  input  wire logic       arm_in,         // Trip after each rise
  input  wire logic       sel_in,         // 0 fault line, 1 current line
  input  wire logic       sync_on_in,     // Pulse the sync source
  output logic            fault_out,
  output logic            curlim_out,
  output logic [7:0]      sync_src_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       hi_q;  // Last seen switch drive
  logic [4:0] age;   // Cycles since the last turn-on
  logic [4:0] tick;  // Sync source divider, 20 cycles
  logic       trip;  // Comparator trip window
  // Track turn-on age and the sync divider
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_q <= 1'b0;
      age  <= 5'h1f;
      tick <= 5'h0;
    end else begin
      hi_q <= high_output_in;
      if (high_output_in && !hi_q) age <= 5'h0;
      else if (age != 5'h1f) age <= age + 5'h1;
      tick <= (tick == 5'h13) ? 5'h0 : tick + 5'h1;
    end
  end
  // Trip three cycles long, well inside a ten-cycle blanking interval
  assign trip = arm_in && age >= 5'h3 && age < 5'h6;
  assign fault_out = trip && !sel_in;
  assign curlim_out = trip && sel_in;
  // Only source 3 carries pulses; other sources stay pulled low
  assign sync_src_out = {4'h0, sync_on_in && tick == 5'h0, 3'h0};
endmodule

// ==== bench/smpwm_properties.sv ====
module smpwm_props (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic        pready_out,
  input  wire logic        pslverr_out,
  input  wire logic [31:0] prdata_out,
  input  wire logic        high_output_out,
  input  wire logic        low_output_out,
  input  wire logic        sync_pulse_out,
  input  wire logic        trig_out
);
  logic [5:0] age;   // Cycles since last write; 63 outlasts a period
  logic [6:0] oc_q;  // Snooped output control
  logic       en_q;  // Snooped time base enable
  logic       wr;
  logic       settled;
  logic       mapped;
  logic       plain;
  assign wr = psel_in && penable_in && pready_out && pwrite_in;
  assign settled = age == 6'h3f;
  assign mapped = paddr_in <= smpwm_pkg::OFF_STATUS && paddr_in[1:0] == 2'h0;
  // Complementary with no override mode armed
  assign plain = oc_q[1:0] == smpwm_pkg::MODE_COMPL && !oc_q[6] && !oc_q[2];
  // Shadow control state from accepted writes
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      age  <= 6'h0;
      oc_q <= 7'h0;
      en_q <= 1'b0;
    end else if (ce_in) begin
      age <= wr ? 6'h0 : (settled ? age : age + 6'h1);
      if (wr && paddr_in == smpwm_pkg::OFF_OUT_CTL) oc_q <= pwdata_in[6:0];
      if (wr && paddr_in == smpwm_pkg::OFF_TB_CTL) en_q <= pwdata_in[0];
    end
  end
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in || !ce_in);
  sequence apb_access;
    psel_in && !penable_in ##1 psel_in && penable_in && !pready_out;
  endsequence
  ready_wait_a: assert property (apb_access |=> pready_out)
    else $error("bus answer not after one wait state");
  ready_pulse_a: assert property (pready_out |-> penable_in ##1 !pready_out)
    else $error("ready outside access or longer than one cycle");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data not zero outside answer");
  slverr_map_a: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("error response does not match address map");
  sync_trig_a: assert property (sync_pulse_out |-> trig_out ##1 !sync_pulse_out)
    else $error("sync pulse without trigger or too long");
  compl_inverse_a: assert property (settled && en_q && plain |-> low_output_out == !high_output_out)
    else $error("low output not inverse of high");
  pp_exclusive_a: assert property (settled && oc_q[1:0] == smpwm_pkg::MODE_PP |-> !(high_output_out && low_output_out))
    else $error("both push-pull outputs on");
  idle_quiet_a: assert property (settled && !en_q |-> !high_output_out && !low_output_out)
    else $error("outputs active while disabled");
endmodule
bind smpwm_top smpwm_props u_props (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prdata_out(prdata_out), .high_output_out(high_output_out),
  .low_output_out(low_output_out), .sync_pulse_out(sync_pulse_out),
  .trig_out(trig_out));

// ==== bench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic err;} smpwm_row_t;
  typedef struct {logic [7:0] oc; logic [15:0] bl; logic s, h, l;} smpwm_trip_t;
  logic        clk, rst_n, psel, penable, pwrite, arm, sel, sync_on;
  logic        pready, pslverr, hi, lo, spulse, fault, curlim, er, tr, crst;
  logic [7:0]  paddr, sync_src;
  logic [31:0] pwdata, prdata, rd;
  int          failures, tests_run, hc, lc, sc, tc;
  // Register writes with the value that reads back
  smpwm_row_t rows [8] = '{
    '{smpwm_pkg::OFF_TB_CTL, 32'h1e, 32'h1e, 1'b0},
    '{smpwm_pkg::OFF_PERIOD, 32'hffffffff, 32'h1fff, 1'b0},
    '{smpwm_pkg::OFF_DUTY, 32'haaaa, 32'haaa, 1'b0},
    '{smpwm_pkg::OFF_PHASE, 32'h1234, 32'h1234, 1'b0},
    '{smpwm_pkg::OFF_OUT_CTL, 32'hffffffff, 32'h7f, 1'b0},
    '{smpwm_pkg::OFF_BLANK, 32'hffffffff, 32'hfff8, 1'b0},
    '{8'h1c, 32'hffffffff, 32'h0, 1'b1},
    '{8'h80, 32'hffffffff, 32'h0, 1'b1}};
  // Trip cases: control, blanking, line, outputs expected after the trip
  smpwm_trip_t trips [8] = '{
    '{8'h50, 16'h0000, 1'b0, 1'b0, 1'b1},
    '{8'h50, 16'h8828, 1'b0, 1'b1, 1'b0},
    '{8'h50, 16'h4828, 1'b0, 1'b0, 1'b1},
    '{8'h50, 16'h1828, 1'b0, 1'b1, 1'b0},
    '{8'h50, 16'h8808, 1'b0, 1'b0, 1'b1},
    '{8'h04, 16'h0000, 1'b1, 1'b0, 1'b0},
    '{8'h04, 16'h8428, 1'b1, 1'b1, 1'b0},
    '{8'h04, 16'h8828, 1'b1, 1'b0, 1'b0}};
  smpwm_top DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .sync_src_in(sync_src), .fault_in(fault),
    .curlim_in(curlim), .cur_reset_in(crst), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .high_output_out(hi),
    .low_output_out(lo), .sync_pulse_out(spulse), .trig_out(tr));
  smpwm_far_model u_far (.clk_in(clk), .rst_n_in(rst_n), .high_output_in(hi),
    .arm_in(arm), .sel_in(sel), .sync_on_in(sync_on), .fault_out(fault),
    .curlim_out(curlim), .sync_src_out(sync_src));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus transfer; waits for the answer, not a fixed count
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("bus_wait", 32'h0, 32'h1);
  endtask
  task pwm(input logic [31:0] per, dc, input logic [31:0] oc, tb);
    apb(1'b1, smpwm_pkg::OFF_PERIOD, per);
    apb(1'b1, smpwm_pkg::OFF_DUTY, dc);
    apb(1'b1, smpwm_pkg::OFF_OUT_CTL, oc);
    apb(1'b1, smpwm_pkg::OFF_TB_CTL, tb);
    repeat (120) @(posedge clk);
  endtask
  // Count high, low and sync cycles over a whole number of periods
  task cnt(input int n);
    hc = 0;
    lc = 0;
    sc = 0;
    tc = 0;
    repeat (n) begin
      @(posedge clk);
      hc += hi;
      lc += lo;
      sc += spulse;
      tc += tr;
    end
  endtask
  task wait_hi(input logic v);
    int n;
    n = 0;
    while (hi !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) chk("edge_wait", 32'h0, 32'h1);
  endtask
  task finish_test;
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog, far beyond the few thousand cycles the run needs
  initial begin
    #200000;
    failures++;
    finish_test;
  end
  initial begin
    {rst_n, psel, penable, pwrite, arm, sel, sync_on, crst} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk("write_err", er, rows[i].err);
      apb(1'b0, rows[i].a, 32'h0);
      chk("read_data", rd, rows[i].e);
      chk("read_err", er, rows[i].err);
    end
    apb(1'b1, smpwm_pkg::OFF_BLANK, 32'h0);
    // Phase left over from the register rows; generator idle, so no pulse
    apb(1'b1, smpwm_pkg::OFF_PHASE, 32'h0);
    pwm(9, 3, 32'h00, 32'h01);
    cnt(100);
    chk("edge_high", hc, 40);
    chk("edge_low", lc, 60);
    chk("edge_sync", sc, 10);
    chk("edge_trig", tc, 10);
    // Phase moves only while the output is off; a lead of 2 leaves 2 counts
    wait_hi(1'b0);
    apb(1'b1, smpwm_pkg::OFF_PHASE, 32'h2);
    repeat (20) @(posedge clk);
    cnt(100);
    chk("phase_high", hc, 20);
    wait_hi(1'b0);
    apb(1'b1, smpwm_pkg::OFF_PHASE, 32'h0);
    pwm(9, 3, 32'h02, 32'h01);
    cnt(200);
    chk("pp_high", hc, 40);
    chk("pp_low", lc, 40);
    pwm(49, 29, 32'h00, 32'h01);
    foreach (trips[i]) begin
      apb(1'b1, smpwm_pkg::OFF_OUT_CTL, 32'(trips[i].oc));
      apb(1'b1, smpwm_pkg::OFF_BLANK, 32'(trips[i].bl));
      sel <= trips[i].s;
      arm <= 1'b1;
      wait_hi(1'b0);
      wait_hi(1'b1);
      repeat (8) @(posedge clk);
      chk("trip_high", hi, trips[i].h);
      chk("trip_low", lo, trips[i].l);
      arm <= 1'b0;
    end
    repeat (60) @(posedge clk);
    cnt(500);
    chk("resume_high", hc, 300);
    sync_on <= 1'b1;
    // Local period of 50 outlasts the 20-cycle master sync, so it follows
    pwm(49, 9, 32'h00, 32'h0f);
    cnt(400);
    chk("sync_high", hc, 200);
    chk("sync_pulse", sc, 0);
    pwm(49, 9, 32'h00, 32'h0b);
    cnt(400);
    chk("other_high", hc, 80);
    chk("other_pulse", sc, 8);
    // Reset request always present: each cycle ends at the first off count
    crst <= 1'b1;
    pwm(49, 9, 32'h08, 32'h01);
    cnt(220);
    chk("crst_high", hc, 200);
    chk("crst_low", lc, 20);
    chk("crst_sync", sc, 0);
    crst <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("reset_out", {hi, lo}, 2'b00);
    rst_n <= 1'b1;
    apb(1'b0, smpwm_pkg::OFF_TB_CTL, 32'h0);
    chk("reset_ctl", rd, 32'h0);
    finish_test;
  end
endmodule
